// ### pkg/adcsc_if.sv
// Interface joining the converter end and the host end of the serial link.
`timescale 1ns/1ps
`default_nettype none
interface adcsc_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
  modport host (output cs_n, output sck, output sdi, input sdo, input sdo_oe);
endinterface : adcsc_if
`default_nettype wire

// ### pkg/adcsc_pkg.sv
// Package of constants shared by both ends of the converter serial link.
package adcsc_pkg;
  localparam int WORD_BITS = 32;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 5;
  localparam int RESULT_BITS = 23;
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYCLES = (POR_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES_DEFAULT = 2000;
  // Fall to sample takes six bus clocks through both synchronisers.
  localparam int SCK_HALF_DEFAULT = 8;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [2:0] CTRL_UPDATE = 3'h5;
  localparam logic [2:0] CTRL_KEEP = 3'h4;
  localparam logic [2:0] CTRL_ZERO = 3'h0;
  localparam int CMD_CTRL_LSB = 5;
  localparam int ADDR_SINGLE_POS = 4;
  localparam int ADDR_ODD_POS = 3;
  localparam int ADDR_PAIR_MSB = 2;
  // Host register offsets on the AHB-Lite bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_ABORT_POS = 1;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_DONE_POS = 1;
  localparam int STAT_EOC_POS = 2;
  localparam int STAT_PERR_POS = 3;
endpackage : adcsc_pkg

// ### testbench/adc_serial_channel_select_tb.sv
// Testbench joining the host end and the converter end over the link.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_channel_select_tb;
  logic hclk, hresetn, supply_low, sign_in, hwrite, hreadyout;
  logic [22:0] value_in;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [3:0] pos, neg;
  logic [4:0] maddr;
  logic common_neg, freq_pin, notch, isck, hresp;
  int n_errors, checks;
  logic [7:0] cmds [8] = '{8'hB5, 8'h9F, 8'h00, 8'hAB, 8'hA6, 8'hBF,
    8'hA0, 8'hB8};
  adcsc_if link_a ();
  adcsc_device #(.POR_CYC(50), .CONV_CYC(200)) i_adcsc_device (
    .hclk(hclk), .hresetn(hresetn), .supply_low(supply_low),
    .frequency_control_pin(freq_pin), .result_sign_bit(sign_in),
    .result_value(value_in), .link(link_a.device), .mux_pos_channel(pos),
    .mux_neg_channel(neg), .common_negative_input(common_neg),
    .mux_address(maddr), .internal_sck_mode(isck),
    .slow_notch_select(notch));
  adcsc_host #(.SCK_HALF(8)) i_adcsc_host (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link(link_a.host));
  adcsc_assertions i_adcsc_assertions (
    .hclk(hclk), .hresetn(hresetn), .cs_n(link_a.cs_n), .sck(link_a.sck),
    .sdi(link_a.sdi), .sdo(link_a.sdo), .sdo_oe(link_a.sdo_oe));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // One AHB-Lite single word transfer; read data taken at the data edge.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask : bus
  // Sends a command, starts a frame, waits until idle and reads the word.
  task automatic frame(input logic [7:0] cmd, output logic [31:0] w,
    output logic [31:0] st);
    logic [31:0] q;
    int n;
    bus(1'h1, adcsc_pkg::REG_CMD, {24'h0, cmd}, q);
    bus(1'h1, adcsc_pkg::REG_CTRL, 32'h1, q);
    st = 32'h1;
    n = 0;
    while (st[adcsc_pkg::STAT_BUSY_POS] !== 1'h0 && n < 3000) begin
      bus(1'h0, adcsc_pkg::REG_STATUS, 32'h0, st);
      n++;
    end
    chk("frame_end", 32'h0, {31'h0, st[adcsc_pkg::STAT_BUSY_POS]});
    bus(1'h0, adcsc_pkg::REG_DATA, 32'h0, w);
  endtask : frame
  function automatic logic [31:0] expw(input logic s,
    input logic [22:0] v, input logic [4:0] a);
    logic [30:0] b;
    b = {2'h0, s, v, a};
    return {b, ^b};
  endfunction : expw
  task automatic chk_mux(input logic [4:0] a);
    chk("mux_address", {27'h0, a}, {27'h0, maddr});
    chk("mux_pos", {28'h0, a[2:0], a[3]}, {28'h0, pos});
    chk("common", {31'h0, a[4]}, {31'h0, common_neg});
    if (!a[4]) chk("mux_neg", {28'h0, a[2:0], ~a[3]}, {28'h0, neg});
  endtask : chk_mux
  // Free-running bus clock.
  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end
  // Cuts a hung run short.
  initial begin
    #3000000;
    n_errors++;
    tally_and_finish();
  end
  // Main sequence of frames, aborts and supply drops.
  initial begin
    logic [31:0] w, st, q, ew;
    logic [4:0] cur;
    hresetn = 1'h0;
    supply_low = 1'h0;
    freq_pin = 1'h0;
    sign_in = 1'h1;
    value_in = 23'h12345;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("cs_n_idle", 32'h1, {31'h0, link_a.cs_n});
    chk("sdo_oe_idle", 32'h0, {31'h0, link_a.sdo_oe});
    repeat (300) @(posedge hclk);
    chk_mux(5'h00);
    cur = 5'h00;
    for (int i = 0; i < 8; i++) begin
      ew = expw(sign_in, value_in, cur);
      frame(cmds[i], w, st);
      chk("data_word", ew, w);
      chk("status", 32'h1 << adcsc_pkg::STAT_DONE_POS, {28'h0, st[3:0]});
      if (cmds[i][7:5] === adcsc_pkg::CTRL_UPDATE) cur = cmds[i][4:0];
      sign_in <= ~sign_in;
      value_in <= value_in + 23'h0F1357;
      repeat (5) @(posedge hclk);
      chk_mux(cur);
      repeat (250) @(posedge hclk);
    end
    ew = expw(sign_in, value_in, cur);
    sign_in <= ~sign_in;
    value_in <= 23'h7FFFFF;
    bus(1'h1, adcsc_pkg::REG_CTRL, 32'h1, q);
    bus(1'h1, adcsc_pkg::REG_CTRL, 32'h2, q);
    repeat (20) @(posedge hclk);
    frame(8'h00, w, st);
    chk("kept_word", ew, w);
    frame(8'h00, w, st);
    chk("eoc_seen", 32'h1, {31'h0, st[adcsc_pkg::STAT_EOC_POS]});
    chk("next_word", expw(sign_in, value_in, cur), w);
    supply_low <= 1'h1;
    freq_pin <= 1'h1;
    repeat (20) @(posedge hclk);
    chk_mux(5'h00);
    chk("notch", 32'h1, {31'h0, notch});
    supply_low <= 1'h0;
    repeat (300) @(posedge hclk);
    frame(8'h00, w, st);
    chk("por_word", expw(sign_in, value_in, 5'h00), w);
    bus(1'h0, 8'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("sck_mode", 32'h0, {31'h0, isck});
    tally_and_finish();
  end
endmodule : adc_serial_channel_select_tb
`default_nettype wire

// ### testbench/adcsc_assertions.sv
// Checker of the serial link between the converter end and the host end.
`timescale 1ns/1ps
`default_nettype none
module adcsc_assertions (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Link signals.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  localparam int END_WAIT = 40;
  logic sck_q;
  logic [5:0] n_rise;
  logic par;
  wire logic sck_rise = sck && !sck_q;
  // Counts clock rises and keeps running parity of the bits within a frame.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_q <= 1'h0;
      n_rise <= 6'h00;
      par <= 1'h0;
    end else begin
      sck_q <= sck;
      n_rise <= cs_n ? 6'h00 : n_rise + {5'h00, sck_rise};
      par <= cs_n ? 1'h0 : par ^ (sck_rise & sdo);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Link timing and word format, seen from the wire.
  a_sdo_steady_high: assert property (
    !cs_n && sck && $past(sck) |-> $stable(sdo))
    else $error("sdo changed while the serial clock was high");
  a_eoc_first_low: assert property (
    sck_rise && n_rise == 6'h00 |-> !sdo)
    else $error("first output bit was not a low end flag");
  a_dummy_bit_zero: assert property (
    sck_rise && n_rise == 6'h01 |-> !sdo)
    else $error("second output bit was not zero");
  a_parity_bit_ok: assert property (
    sck_rise && n_rise == 6'h1F |-> sdo == par)
    else $error("last output bit does not match parity");
  a_frame_max_bits: assert property (sck_rise |-> n_rise < 6'h20)
    else $error("more than 32 clock rises in one frame");
  a_frame_closes: assert property (
    n_rise == 6'h20 |-> ##[0:END_WAIT] cs_n)
    else $error("chip select not released after 32 bits");
  a_select_drives: assert property ($fell(cs_n) |-> ##[1:8] sdo_oe)
    else $error("sdo not driven after chip select fell");
  a_release_sdo: assert property ($rose(cs_n) |-> ##[1:8] !sdo_oe)
    else $error("sdo still driven after chip select rose");
  a_clock_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock moved outside a frame");
  // Main scenarios reached.
  c_full_frame: cover property ($rose(cs_n) && n_rise == 6'h20);
  c_early_abort: cover property ($rose(cs_n) && n_rise == 6'h00);
  c_eoc_wait: cover property (!cs_n && sdo_oe && sdo);
  c_sdi_high: cover property (sck_rise && sdi);
endmodule : adcsc_assertions
`default_nettype wire

// ### verilog/adcsc_device.sv
// Converter end: conversion, sleep and serial output cycle with mux select.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] New channel selection governs the next conversion.
// [RL2] Output changes on falling edge; host samples rising.
// [RL3] Output ends after 32 bits or chip-select high.
// [RL4] Modes set only by chip-select and clock timing.
// [RL5] Calibration hidden inside each conversion cycle.
// [RL6] Each word belongs to exactly one conversion.
// [RL7] Held in reset while supply is low.
// [RL8] Power-on reset of about 1ms clears registers.
// [RL9] First conversion uses address zero.
// [RL10] Input bits captured on rising serial-clock edge.
// [RL11] Input word: three control, five address bits.
// [RL12] Host sends 1 then 0 first.
// [RL13] Enable bit one replaces selection, zero keeps.
// [RL14] All-zero control field keeps selection.
// [RL15] Host sends only 101, 100 or 000.
// [RL16] Single-ended select: zero differential, one single-ended.
// [RL17] Differential picks pair 2k, 2k+1; odd swaps.
// [RL18] Single-ended positive 2k+odd, common pin negative.
// [RL19] Eight-channel variant: top pair bit zero.
// [RL20] Chip-select high before first rising edge: sleep.
// [RL21] Clock mode latched at power-up or chip-select fall.
// [RL22] Word: flag, dummy, sign, 23 result, address, parity.
// [RL23] Chip select low outside output shows the flag.
module adcsc_device #(
  parameter int POR_CYC = adcsc_pkg::POR_CYCLES,
  parameter int CONV_CYC = adcsc_pkg::CONV_CYCLES_DEFAULT
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Supply-low indication and frequency control pin.
  input wire logic supply_low,
  input wire logic frequency_control_pin,
  // Conversion result from the analog core, sampled at conversion end.
  input wire logic result_sign_bit,
  input wire logic [adcsc_pkg::RESULT_BITS-1:0] result_value,
  // Serial link.
  adcsc_if.device link,
  // Multiplexer selection towards the analog front end, clock mode flag and notch select.
  output logic [3:0] mux_pos_channel,
  output logic [3:0] mux_neg_channel,
  output logic common_negative_input,
  output logic [adcsc_pkg::ADDR_BITS-1:0] mux_address,
  output logic internal_sck_mode,
  output logic slow_notch_select
);
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_CONV = 4'h2,
    ST_SLEEP = 4'h4,
    ST_OUT = 4'h8
  } adcsc_state_t;

  adcsc_state_t state;
  adcsc_state_t next_state;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic supply_low_s;
  logic freq_s;
  logic sck_d;
  logic cs_n_d;
  logic [19:0] count;
  logic [5:0] bit_cnt;
  logic started;
  logic [31:0] shreg;
  logic [7:0] cmd;
  logic [4:0] conv_addr;
  logic [4:0] next_addr;
  logic [23:0] result_hold;
  logic sdo_bit;

  // Every pin from the far side passes two flip-flops.
  adcsc_sync #(.INIT(1'b1)) u_cs (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.cs_n), .sync_out(cs_n_s));
  adcsc_sync #(.INIT(1'b0)) u_sck (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.sck), .sync_out(sck_s));
  adcsc_sync #(.INIT(1'b0)) u_sdi (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.sdi), .sync_out(sdi_s));
  adcsc_sync #(.INIT(1'b1)) u_sup (.hclk(hclk), .hresetn(hresetn),
    .async_in(supply_low), .sync_out(supply_low_s));
  adcsc_sync #(.INIT(1'b0)) u_freq (.hclk(hclk), .hresetn(hresetn),
    .async_in(frequency_control_pin), .sync_out(freq_s));

  // Edge decode of the synchronised link signals.
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire cs_fall = ~cs_n_s & cs_n_d;
  wire cs_rise = cs_n_s & ~cs_n_d;
  wire in_out = (state == ST_OUT);
  wire last_bit = (bit_cnt == 6'(adcsc_pkg::WORD_BITS));
  wire conv_done = (state == ST_CONV) && (count == 20'(CONV_CYC - 1));
  wire por_done = (state == ST_RESET) && (count == 20'(POR_CYC - 1));
  wire [2:0] ctrl = cmd[7:5];
  wire addr_take = in_out && (bit_cnt == 6'(adcsc_pkg::CMD_BITS))
    && (ctrl == adcsc_pkg::CTRL_UPDATE); // [RL13]
  wire [7:0] cmd_next = {cmd[6:0], sdi_s};
  // Parity over bits 31 to 1; the end-of-conversion flag there is zero.
  wire parity = ^{2'b00, result_hold, conv_addr};

  // Next-state decode of the conversion, sleep and output cycle.
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (por_done) begin
          next_state = ST_CONV; // [RL8]
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          next_state = ST_SLEEP; // [RL5]
        end
      end
      ST_SLEEP: begin
        if (cs_fall || !cs_n_s) begin
          next_state = ST_OUT;
        end
      end
      ST_OUT: begin
        if (cs_rise && !started) begin
          next_state = ST_SLEEP; // [RL20]
        end else if (cs_rise || (last_bit && sck_fall)) begin
          next_state = ST_CONV; // [RL3]
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  // Sequencer state, counters and supply-low hold.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_RESET;
      count <= 20'h00000;
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
      if (supply_low_s) begin
        state <= ST_RESET; // [RL7]
        count <= 20'h00000;
      end else begin
        state <= next_state; // [RL4]
        if (next_state != state) begin
          count <= 20'h00000;
        end else begin
          count <= count + 20'h00001;
        end
      end
    end
  end

  // Result capture, serial shifting and channel selection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_hold <= 24'h000000;
      shreg <= 32'h00000000;
      cmd <= 8'h00;
      bit_cnt <= 6'h00;
      started <= 1'b0;
      conv_addr <= adcsc_pkg::ADDR_RESET; // [RL9]
      next_addr <= adcsc_pkg::ADDR_RESET;
      sdo_bit <= 1'b1;
      internal_sck_mode <= 1'b0;
    end else if (supply_low_s || state == ST_RESET) begin
      result_hold <= 24'h000000; // [RL8]
      shreg <= 32'h00000000;
      cmd <= 8'h00;
      bit_cnt <= 6'h00;
      started <= 1'b0;
      conv_addr <= adcsc_pkg::ADDR_RESET;
      next_addr <= adcsc_pkg::ADDR_RESET;
      sdo_bit <= 1'b1;
      internal_sck_mode <= sck_s; // [RL21]
    end else begin
      if (cs_fall) begin
        internal_sck_mode <= sck_s; // [RL21]
      end
      if (state == ST_CONV) begin
        sdo_bit <= 1'b1; // [RL23]
        bit_cnt <= 6'h00;
        started <= 1'b0;
        cmd <= 8'h00;
        if (conv_done) begin
          result_hold <= {result_sign_bit, result_value}; // [RL6]
          sdo_bit <= 1'b0;
        end
      end else if (state == ST_SLEEP) begin
        sdo_bit <= 1'b0; // [RL23]
        shreg <= {2'b00, result_hold, conv_addr, parity}; // [RL22]
        bit_cnt <= 6'h00;
        started <= 1'b0;
      end else if (in_out) begin
        if (sck_rise && !last_bit) begin
          cmd <= cmd_next; // [RL10] [RL11]
          bit_cnt <= bit_cnt + 6'h01;
          started <= 1'b1;
        end
        if (sck_fall && started) begin
          shreg <= {shreg[30:0], 1'b0};
          sdo_bit <= shreg[30]; // [RL2]
        end else if (!started) begin
          sdo_bit <= shreg[31];
        end
        if (addr_take) begin
          next_addr <= cmd[4:0]; // [RL1]
        end
        if (next_state == ST_CONV) begin
          conv_addr <= next_addr; // [RL1] [RL14]
        end
      end
    end
  end

  // Output pins and multiplexer decode driven from flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.sdo <= 1'b0;
      link.sdo_oe <= 1'b0;
      mux_pos_channel <= 4'h0;
      mux_neg_channel <= 4'h1;
      common_negative_input <= 1'b0;
      mux_address <= 5'h00;
      slow_notch_select <= 1'b0;
    end else begin
      link.sdo <= sdo_bit;
      link.sdo_oe <= ~cs_n_s && (state != ST_RESET);
      slow_notch_select <= freq_s;
      mux_address <= conv_addr;
      if (conv_addr[adcsc_pkg::ADDR_SINGLE_POS]) begin
        mux_pos_channel <= {conv_addr[2:0], conv_addr[3]}; // [RL16] [RL18]
        mux_neg_channel <= 4'h0;
        common_negative_input <= 1'b1;
      end else begin
        mux_pos_channel <= {conv_addr[2:0], conv_addr[3]}; // [RL17]
        mux_neg_channel <= {conv_addr[2:0], ~conv_addr[3]};
        common_negative_input <= 1'b0;
      end
    end
  end
endmodule : adcsc_device
`default_nettype wire

// ### verilog/adcsc_host.sv
// Host end: AHB-Lite registers driving one serial read/select frame.
`timescale 1ns/1ps
`default_nettype none
module adcsc_host #(
  parameter int SCK_HALF = adcsc_pkg::SCK_HALF_DEFAULT
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial link.
  adcsc_if.host link
);
  logic sdo_s;
  logic busy;
  logic done;
  logic [7:0] cmd;
  logic [7:0] txsh;
  logic [31:0] rxsh;
  logic [31:0] data;
  logic [5:0] bits;
  logic [7:0] div;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic eoc;

  adcsc_sync #(.INIT(1'b0)) u_sdo (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.sdo), .sync_out(sdo_s));

  // Address-phase decode and register selection.
  wire take = hsel && hready && htrans[1];
  wire wr_ctrl = wr_pend && (wr_addr == adcsc_pkg::REG_CTRL);
  wire wr_cmd = wr_pend && (wr_addr == adcsc_pkg::REG_CMD);
  wire start = wr_ctrl && hwdata[adcsc_pkg::CTRL_START_POS] && !busy;
  wire abort = wr_ctrl && hwdata[adcsc_pkg::CTRL_ABORT_POS] && busy;
  wire half = (div == 8'(SCK_HALF - 1));
  wire perr = ^data;
  wire [31:0] status = {28'h0000000, perr, eoc, done, busy};
  wire [31:0] rd_mux = (haddr == adcsc_pkg::REG_CTRL) ? 32'h00000000 :
    (haddr == adcsc_pkg::REG_CMD) ? {24'h000000, cmd} :
    (haddr == adcsc_pkg::REG_STATUS) ? status :
    (haddr == adcsc_pkg::REG_DATA) ? data : 32'h00000000;

  // Bus slave: zero-wait writes land in the data phase, reads are registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cmd <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      wr_addr <= haddr;
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_cmd) begin
        cmd <= hwdata[7:0]; // [RL12] [RL15] [RL19]
      end
    end
  end

  // Frame engine: host makes the serial clock by dividing hclk.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      txsh <= 8'h00;
      rxsh <= 32'h00000000;
      data <= 32'h00000000;
      bits <= 6'h00;
      div <= 8'h00;
      eoc <= 1'b0;
    end else begin
      if (wr_ctrl && hwdata[adcsc_pkg::CTRL_START_POS]) begin
        done <= 1'b0;
      end
      if (start) begin
        busy <= 1'b1;
        link.cs_n <= 1'b0;
        link.sdi <= cmd[7]; // [RL11]
        txsh <= {cmd[6:0], 1'b0};
        bits <= 6'h00;
        div <= 8'h00;
        eoc <= 1'b0;
      end else if (abort) begin
        busy <= 1'b0;
        link.cs_n <= 1'b1; // [RL3]
        link.sck <= 1'b0;
      end else if (busy) begin
        div <= half ? 8'h00 : div + 8'h01;
        if (half && bits == 6'h00 && !link.sck && sdo_s) begin
          eoc <= 1'b1; // [RL23]
        end else if (half && !link.sck) begin
          link.sck <= 1'b1;
          rxsh <= {rxsh[30:0], sdo_s}; // [RL2]
          bits <= bits + 6'h01;
        end else if (half) begin
          link.sck <= 1'b0;
          link.sdi <= txsh[7];
          txsh <= {txsh[6:0], 1'b0};
          if (bits == 6'(adcsc_pkg::WORD_BITS)) begin
            busy <= 1'b0;
            done <= 1'b1;
            data <= rxsh;
            link.cs_n <= 1'b1;
          end
        end
      end
    end
  end
endmodule : adcsc_host
`default_nettype wire

// ### verilog/adcsc_sync.sv
// Two-flip-flop synchroniser for one level from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module adcsc_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous level in, synchronised level out.
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : adcsc_sync
`default_nettype wire
